// >>> rtl/can_ctrl_regs.vh
/*
 * register offsets, field positions, reset values and alias offsets for the
 * CAN interrupt and filter control slice. assumes byte addressing on the bus.
 */
`ifndef CAN_CTRL_REGS_VH
`define CAN_CTRL_REGS_VH

// base byte addresses
`define ADDR_CONTROL        8'h00
`define ADDR_INT            8'h20
`define ADDR_FILTER         8'hE0
// set/clear/invert alias offsets
`define ALIAS_BASE          2'h0
`define ALIAS_CLR           2'h1
`define ALIAS_SET           2'h2
`define ALIAS_INV           2'h3
// control register
`define CTRL_ON_BIT         15
// interrupt register layout
`define INT_ENABLE_MASK     32'hF80F0000
`define INT_FLAG_MASK       32'h0000F80F
`define INT_SYSERR_BIT      12
`define INT_RESET           32'h00000000
`define FILTER_RESET        32'h00000000
`define CTRL_RESET          32'h00000000
// filter byte layout
`define FLT_EN_BIT          7
`define FLT_MSEL_HI         6
`define FLT_MSEL_LO         5
`define FLT_FSEL_HI         4
`define FLT_FSEL_LO         0
`define FSEL_RESERVED_BIT   4

`endif

// >>> rtl/can_filter_byte.v
/*
 * one filter's control byte with its enable-gated update and decoded outputs.
 * assumes the parent supplies the value the byte would take after a write.
 */
`timescale 1ns/1ps
`include "can_ctrl_regs.vh"

module can_filter_byte (
  // clock and reset
  input  wire       i_core_clk,
  input  wire       i_reset_n,
  // update request
  input  wire       i_write,
  input  wire [7:0] i_new_byte,
  // state
  output reg  [7:0] o_byte_q,
  output reg  [3:0] o_mask_onehot_q,
  output reg        o_fifo_valid_q
);

  wire       cur_en  = o_byte_q[`FLT_EN_BIT];
  // fields change only while the filter is disabled; enable itself may always move
  wire [7:0] byte_d  = !i_write ? o_byte_q :
                       cur_en  ? {i_new_byte[`FLT_EN_BIT], o_byte_q[6:0]} : // RL9
                                 i_new_byte;

  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_byte_q        <= 8'h00; // RL12
      o_mask_onehot_q <= 4'h0;
      o_fifo_valid_q  <= 1'b0;
    end else begin
      o_byte_q        <= byte_d;
      // mask code n picks acceptance mask n
      o_mask_onehot_q <= byte_d[`FLT_EN_BIT] ?
                         (4'h1 << byte_d[`FLT_MSEL_HI:`FLT_MSEL_LO]) : 4'h0; // RL6 RL5
      // codes 16 to 31 name no fifo
      o_fifo_valid_q  <= byte_d[`FLT_EN_BIT] & ~byte_d[`FSEL_RESERVED_BIT]; // RL7
    end
  end

endmodule // can_filter_byte

// >>> rtl/can_int_filter_ctrl.v
/*
 * interrupt enable/flag register, filter control for filters 8 to 11 and the
 * module on bit, as an avalon-mm slave with waitrequest.
 * assumes event inputs are single-cycle pulses on i_core_clk.
 */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
// Summary of operation
// RL1: nine enable bits at 31..27 and 19..16 allow interrupt requests when set.
// RL2: matching event flags at 15..11 and 3..0 set when their event occurs.
// RL3: unused interrupt bits 26..20 and 10..4 read zero, writes ignored.
// RL4: software cannot clear system error flag; module off then on clears it.
// RL5: filter enable bits 31,23,15,7 include filters 11,10,9,8 in acceptance.
// RL6: two-bit mask select picks acceptance mask 0 to 3.
// RL7: five-bit fifo select picks fifo 0 to 15; 16 to 31 reserved.
// RL8: each filter owns a byte: enable, mask select, fifo select.
// RL9: filter fields change only while that filter is disabled.
// RL10: clear, set and invert aliases at offsets 0x4, 0x8, 0xC.
// RL11: interrupt asserts while any flag and its enable are both set.
// RL12: all implemented bits reset to zero.
`timescale 1ns/1ps
`include "can_ctrl_regs.vh"

module can_int_filter_ctrl (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_reset_n,
  // avalon-mm slave
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  // events from the protocol engine, one-cycle pulses
  input  wire        i_invalid_msg_event,
  input  wire        i_wakeup_event,
  input  wire        i_bus_error_event,
  input  wire        i_system_error_event,
  input  wire        i_rx_overflow_event,
  input  wire        i_mode_change_event,
  input  wire        i_timestamp_event,
  input  wire        i_rx_buffer_event,
  input  wire        i_tx_buffer_event,
  // state toward the protocol engine
  output reg         o_irq,
  output reg         o_module_on,
  output reg  [3:0]  o_filter_enable,
  output reg  [7:0]  o_filter_mask_select,
  output reg  [19:0] o_filter_fifo_select,
  output reg  [3:0]  o_filter_fifo_valid,
  output reg  [15:0] o_filter_mask_onehot
);

  // register state
  reg  [31:0] int_q;
  reg  [31:0] int_d;
  reg  [31:0] ctrl_q;
  reg  [31:0] ctrl_d;
  reg  [31:0] filt_new;
  wire [31:0] filt_q;
  // bus handshake
  reg         ack_q;
  reg  [31:0] rdata_d;
  wire [31:0] wmask;
  wire [1:0]  alias_sel;
  wire        is_ctrl;
  wire        is_int;
  wire        is_filt;
  wire        mapped;
  wire        wr_go;
  wire        ctrl_wr;
  wire        int_wr;
  wire        filt_wr;
  // events and interrupt request
  wire [31:0] ev_bits;
  reg         irq_d;
  wire        on_toggled_on;
  // filter slice state
  wire [15:0] onehot_w;
  wire [3:0]  fvalid_w;
  // interrupt register fields by name
  wire        invalid_msg_irq_enable;
  wire        wakeup_irq_enable;
  wire        bus_error_irq_enable;
  wire        system_error_irq_enable;
  wire        rx_overflow_irq_enable;
  wire        mode_change_irq_enable;
  wire        timestamp_irq_enable;
  wire        rx_buffer_irq_enable;
  wire        tx_buffer_irq_enable;
  wire        invalid_msg_flag;
  wire        wakeup_flag;
  wire        bus_error_flag;
  wire        system_error_flag;
  wire        rx_overflow_flag;
  wire        mode_change_flag;
  wire        timestamp_flag;
  wire        rx_buffer_flag;
  wire        tx_buffer_flag;

  // true when the upper address nibble selects the register at base
  function in_window;
    input [7:0] addr;
    input [7:0] base;
    begin
      in_window = (addr[7:4] == base[7:4]);
    end
  endfunction

  // one wait cycle per access, answer on the second edge
  assign wr_go     = i_avs_write & ack_q;
  assign alias_sel = i_avs_address[3:2];
  assign is_ctrl   = in_window(i_avs_address, `ADDR_CONTROL);
  assign is_int    = in_window(i_avs_address, `ADDR_INT);
  assign is_filt   = in_window(i_avs_address, `ADDR_FILTER);
  assign mapped    = (is_ctrl | is_int | is_filt) & (i_avs_address[1:0] == 2'b00);
  assign ctrl_wr   = wr_go & is_ctrl & mapped;
  assign int_wr    = wr_go & is_int & mapped;
  assign filt_wr   = wr_go & is_filt & mapped;
  assign wmask     = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  // new value of a register after a base, clear, set or invert write
  function [31:0] apply_alias;
    input [31:0] cur;
    input [31:0] wd;
    input [31:0] m;
    input [1:0]  sel;
    begin
      case (sel)
        `ALIAS_BASE: apply_alias = (cur & ~m) | (wd & m);
        `ALIAS_CLR:  apply_alias = cur & ~(wd & m); // RL10
        `ALIAS_SET:  apply_alias = cur | (wd & m); // RL10
        default:     apply_alias = cur ^ (wd & m); // RL10
      endcase
    end
  endfunction

  assign ev_bits = {16'h0000,
                    i_invalid_msg_event, i_wakeup_event, i_bus_error_event,
                    i_system_error_event, i_rx_overflow_event, 7'h00,
                    i_mode_change_event, i_timestamp_event,
                    i_rx_buffer_event, i_tx_buffer_event}; // RL2

  // named views of the next interrupt value; the request follows them
  assign invalid_msg_irq_enable  = int_d[31]; // RL1
  assign wakeup_irq_enable       = int_d[30];
  assign bus_error_irq_enable    = int_d[29];
  assign system_error_irq_enable = int_d[28];
  assign rx_overflow_irq_enable  = int_d[27];
  assign mode_change_irq_enable  = int_d[19];
  assign timestamp_irq_enable    = int_d[18];
  assign rx_buffer_irq_enable    = int_d[17];
  assign tx_buffer_irq_enable    = int_d[16];
  assign invalid_msg_flag        = int_d[15]; // RL2
  assign wakeup_flag             = int_d[14];
  assign bus_error_flag          = int_d[13];
  assign system_error_flag       = int_d[12];
  assign rx_overflow_flag        = int_d[11];
  assign mode_change_flag        = int_d[3];
  assign timestamp_flag          = int_d[2];
  assign rx_buffer_flag          = int_d[1];
  assign tx_buffer_flag          = int_d[0];

  // each enable gates only its own flag
  always @* begin
    irq_d = 1'b0;
    irq_d = irq_d | (invalid_msg_irq_enable & invalid_msg_flag); // RL11
    irq_d = irq_d | (wakeup_irq_enable & wakeup_flag);
    irq_d = irq_d | (bus_error_irq_enable & bus_error_flag);
    irq_d = irq_d | (system_error_irq_enable & system_error_flag);
    irq_d = irq_d | (rx_overflow_irq_enable & rx_overflow_flag);
    irq_d = irq_d | (mode_change_irq_enable & mode_change_flag);
    irq_d = irq_d | (timestamp_irq_enable & timestamp_flag);
    irq_d = irq_d | (rx_buffer_irq_enable & rx_buffer_flag);
    irq_d = irq_d | (tx_buffer_irq_enable & tx_buffer_flag);
  end

  // module on bit
  always @* begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = apply_alias(ctrl_q, i_avs_writedata, wmask, alias_sel);
    end
    ctrl_d = ctrl_d & (32'h1 << `CTRL_ON_BIT);
  end

  // only the write that turns the module on clears the system error flag
  assign on_toggled_on = ctrl_d[`CTRL_ON_BIT] & ~ctrl_q[`CTRL_ON_BIT];

  // interrupt register: software write, then hardware set wins
  always @* begin
    int_d = int_q;
    if (int_wr) begin
      int_d = apply_alias(int_q, i_avs_writedata, wmask, alias_sel);
      int_d[`INT_SYSERR_BIT] = int_q[`INT_SYSERR_BIT]; // RL4
    end
    if (on_toggled_on) begin
      int_d[`INT_SYSERR_BIT] = 1'b0; // RL4
    end
    int_d = int_d | ev_bits;
    int_d = int_d & (`INT_ENABLE_MASK | `INT_FLAG_MASK); // RL3 RL1
  end

  // filter write image handed to each byte slice
  always @* begin
    filt_new = filt_q;
    if (filt_wr) begin
      filt_new = apply_alias(filt_q, i_avs_writedata, wmask, alias_sel);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_filter
      can_filter_byte u_filter (
        .i_core_clk      (i_core_clk),
        .i_reset_n       (i_reset_n),
        .i_write         (filt_wr),
        .i_new_byte      (filt_new[8*g+7:8*g]), // RL8
        .o_byte_q        (filt_q[8*g+7:8*g]),
        .o_mask_onehot_q (onehot_w[4*g+3:4*g]),
        .o_fifo_valid_q  (fvalid_w[g])
      );
    end
  endgenerate

  // filter enables, filter 11 in the top bit
  function [3:0] pick_enables;
    input [31:0] f;
    integer n;
    begin
      pick_enables = 4'h0;
      for (n = 0; n < 4; n = n + 1) begin
        pick_enables[n] = f[8*n+`FLT_EN_BIT];
      end
    end
  endfunction

  // mask select codes, two bits per filter
  function [7:0] pick_mask_selects;
    input [31:0] f;
    integer n;
    begin
      pick_mask_selects = 8'h00;
      for (n = 0; n < 4; n = n + 1) begin
        pick_mask_selects[2*n+1 -: 2] = f[8*n+`FLT_MSEL_HI -: 2];
      end
    end
  endfunction

  // fifo select codes, five bits per filter
  function [19:0] pick_fifo_selects;
    input [31:0] f;
    integer n;
    begin
      pick_fifo_selects = 20'h00000;
      for (n = 0; n < 4; n = n + 1) begin
        pick_fifo_selects[5*n +: 5] = f[8*n+`FLT_FSEL_LO +: 5];
      end
    end
  endfunction

  // base registers read back; aliases and holes read zero
  always @* begin
    rdata_d = 32'h00000000;
    if (is_int) begin
      rdata_d = int_q; // RL3
    end else if (is_ctrl) begin
      rdata_d = ctrl_q;
    end else if (is_filt) begin
      rdata_d = filt_q;
    end
    if (!mapped || alias_sel != `ALIAS_BASE) begin
      rdata_d = 32'h00000000;
    end
  end

  // bus handshake: waitrequest low for the one cycle that answers
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_q             <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else begin
      ack_q             <= (i_avs_read | i_avs_write) & ~ack_q;
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_q);
    end
  end

  // read data captured at the edge that drops waitrequest, held until the next read
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read & ~ack_q) begin
      o_avs_readdata <= rdata_d;
    end
  end

  // interrupt enables and flags
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_q <= `INT_RESET; // RL12
    end else begin
      int_q <= int_d;
    end
  end

  // control register, only the on bit is kept
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q <= `CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // request follows the next flag state, so it stands with the flags
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_d; // RL11
    end
  end

  // on bit follows the control register
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_module_on <= 1'b0;
    end else begin
      o_module_on <= ctrl_d[`CTRL_ON_BIT];
    end
  end

  // filter outputs lag the slices by one cycle, all in step
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_filter_enable      <= 4'h0;
      o_filter_mask_select <= 8'h00;
      o_filter_fifo_select <= 20'h00000;
      o_filter_fifo_valid  <= 4'h0;
      o_filter_mask_onehot <= 16'h0000;
    end else begin
      o_filter_enable      <= pick_enables(filt_q); // RL5
      o_filter_mask_select <= pick_mask_selects(filt_q); // RL6
      o_filter_fifo_select <= pick_fifo_selects(filt_q); // RL7
      o_filter_fifo_valid  <= fvalid_w;
      o_filter_mask_onehot <= onehot_w;
    end
  end

endmodule // can_int_filter_ctrl

// >>> test/can_int_filter_ctrl_sva.sv
/* checker for the interrupt and filter control slice.
   sees only the top ports; the bind is at the foot of this file. */
`timescale 1ns/1ps
module can_int_filter_ctrl_sva (
  input wire logic        i_core_clk, i_reset_n, i_avs_read, i_avs_write, o_avs_waitrequest,
  input wire logic        o_irq, o_module_on,
  input wire logic [7:0]  i_avs_address, o_filter_mask_select,
  input wire logic [31:0] o_avs_readdata,
  input wire logic [3:0]  o_filter_enable, o_filter_fifo_valid,
  input wire logic [19:0] o_filter_fifo_select,
  input wire logic [15:0] o_filter_mask_onehot
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_req; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
  sequence s_answer; !o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
  sequence s_rd_done; i_avs_read && !o_avs_waitrequest; endsequence
  chk_answer_one_cycle: assert property (s_req |=> s_answer)
    else $error("bus answer not a single cycle");
  chk_idle_wait: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> o_avs_waitrequest) else $error("waitrequest dropped with no request");
  chk_unused_zero: assert property ((s_rd_done and (i_avs_address == 8'h20)) |->
    (o_avs_readdata & 32'h07F007F0) == 32'h0) else $error("unused interrupt bits read nonzero");
  chk_alias_zero: assert property ((s_rd_done and (i_avs_address[3:2] != 2'h0)) |->
    o_avs_readdata == 32'h0) else $error("alias read nonzero");
  chk_fifo_valid: assert property (o_filter_fifo_valid == (o_filter_enable & ~{o_filter_fifo_select[19],
    o_filter_fifo_select[14], o_filter_fifo_select[9], o_filter_fifo_select[4]})) else $error("fifo valid wrong");
  chk_reset_quiet: assert property ($rose(i_reset_n) |-> !o_irq && !o_module_on && o_filter_enable == 4'h0)
    else $error("outputs not cleared by reset");
  for (genvar i = 0; i < 4; i++) begin : g_flt
    chk_mask_onehot: assert property (o_filter_mask_onehot[4*i+:4] ==
      (o_filter_enable[i] ? 4'h1 << o_filter_mask_select[2*i+:2] : 4'h0)) else $error("mask decode wrong");
    chk_fields_locked: assert property ($past(o_filter_enable[i]) && o_filter_enable[i] |->
      $stable({o_filter_mask_select[2*i+:2], o_filter_fifo_select[5*i+:5]})) else $error("enabled filter moved");
  end
endmodule // can_int_filter_ctrl_sva
bind can_int_filter_ctrl can_int_filter_ctrl_sva can_int_filter_ctrl_sva_inst (.i_core_clk(i_core_clk),
  .i_reset_n(i_reset_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_irq(o_irq),
  .o_avs_waitrequest(o_avs_waitrequest), .o_module_on(o_module_on), .i_avs_address(i_avs_address),
  .o_filter_mask_select(o_filter_mask_select), .o_avs_readdata(o_avs_readdata),
  .o_filter_enable(o_filter_enable), .o_filter_fifo_valid(o_filter_fifo_valid),
  .o_filter_fifo_select(o_filter_fifo_select), .o_filter_mask_onehot(o_filter_mask_onehot));

// >>> test/tb_can_int_filter_ctrl.sv
/* bench: avalon-mm master and register model for the control slice.
   assumes one 125 MHz clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module tb_can_int_filter_ctrl;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wq, irq, on;
  logic [7:0]  adr = 8'h00, msel;
  logic [31:0] wd = 32'h0, rdata, im = 32'h0, fm = 32'h0, s = 32'h0CE7, t;
  logic [3:0]  be = 4'hF, fen, fv;
  logic [8:0]  ev = 9'h0, f;
  logic [19:0] fsel;
  logic [15:0] oh;
  int          mismatches = 0, num_checks = 0;
  can_int_filter_ctrl can_int_filter_ctrl_inst (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
    .i_invalid_msg_event(ev[8]), .i_wakeup_event(ev[7]), .i_bus_error_event(ev[6]),
    .i_system_error_event(ev[5]), .i_rx_overflow_event(ev[4]), .i_mode_change_event(ev[3]),
    .i_timestamp_event(ev[2]), .i_rx_buffer_event(ev[1]), .i_tx_buffer_event(ev[0]),
    .o_irq(irq), .o_module_on(on), .o_filter_enable(fen), .o_filter_mask_select(msel),
    .o_filter_fifo_select(fsel), .o_filter_fifo_valid(fv), .o_filter_mask_onehot(oh));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do @(posedge clk); while (wq !== 1'b0);
    t = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic [31:0] mrg(input logic [31:0] c, d, input logic [7:0] a,
                                      input logic [3:0] b);
    logic [31:0] n, m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    case (a[3:2])
      2'h0: n = d;
      2'h1: n = c & ~d;
      2'h2: n = c | d;
      default: n = c ^ d;
    endcase
    return (n & m) | (c & ~m);
  endfunction
  // system error flag is never moved by interrupt register writes
  task automatic wi(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
    im = (mrg(im, d, a, 4'hF) & 32'hF80FE80F) | (im & 32'h00001000);
  endtask
  task automatic wf(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] n;
    n = mrg(fm, d, a, b);
    for (int i = 0; i < 4; i++)
      if (fm[8*i+7]) n[8*i+:7] = fm[8*i+:7];
    bus(1'b1, a, d, b);
    fm = n;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(t, e);
  endtask
  task automatic ci;
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, {31'h0, |(im[31:16] & im[15:0])});
  endtask
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h20, 32'h0);
    rc(8'hE0, 32'h0);
    wi(8'h20, 32'hFFFFFFFF);
    rc(8'h20, im);
    ci;
    wi(8'h24, 32'h0000FFFF);
    rc(8'h20, im);
    ci;
    for (int k = 0; k < 9; k++) begin
      f = 9'h1 << k;
      @(posedge clk);
      ev <= f;
      @(posedge clk);
      ev <= 9'h0;
      im = im | {16'h0, f[8:4], 7'h0, f[3:0]};
      rc(8'h20, im);
      ci;
      wi(8'h2C, {f[8:4], 7'h0, f[3:0], 16'h0});
      ci;
      wi(8'h24, 32'h0000FFFF);
    end
    rc(8'h20, 32'h00001000);
    bus(1'b1, 8'h00, 32'h0, 4'hF);
    bus(1'b1, 8'h00, 32'h00008000, 4'hF);
    im[12] = 1'b0;
    rc(8'h20, im);
    chk({31'h0, on}, 32'h1);
    bus(1'b1, 8'h40, 32'hFFFFFFFF, 4'hF);
    rc(8'h40, 32'h0);
    rc(8'h28, 32'h0);
    repeat (60) begin
      s = nx(s);
      wf(8'hE0 + {s[9:8], 2'h0}, nx(s), s[4] ? 4'hF : s[3:0]);
      rc(8'hE0, fm);
      repeat (2) @(posedge clk);
      chk({fen, msel, fsel}, {fm[31], fm[23], fm[15], fm[7], fm[30:29], fm[22:21], fm[14:13],
        fm[6:5], fm[28:24], fm[20:16], fm[12:8], fm[4:0]});
      for (int i = 0; i < 4; i++) begin
        chk({31'h0, fv[i]}, {31'h0, fm[8*i+7] & ~fm[8*i+4]});
        chk({28'h0, oh[4*i+:4]}, {28'h0, fm[8*i+7] ? 4'h1 << fm[8*i+5+:2] : 4'h0});
      end
    end
    print_verdict;
  end
endmodule // tb_can_int_filter_ctrl
